/* File: hw/ccp_pkg.sv */
// Shared constants, types and state layouts for the capture/compare/PWM unit
package ccp_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register indices (byte address is four times the index)
    localparam logic [7:0] CCP_IDX_PIN_DATA = 8'h07;
    localparam logic [7:0] CCP_IDX_PFLAGS = 8'h0C;
    localparam logic [7:0] CCP_IDX_T1_LO = 8'h0E;
    localparam logic [7:0] CCP_IDX_T1_HI = 8'h0F;
    localparam logic [7:0] CCP_IDX_T1_CTL = 8'h10;
    localparam logic [7:0] CCP_IDX_T2_CNT = 8'h11;
    localparam logic [7:0] CCP_IDX_T2_CTL = 8'h12;
    localparam logic [7:0] CCP_IDX_VAL_LO = 8'h15;
    localparam logic [7:0] CCP_IDX_VAL_HI = 8'h16;
    localparam logic [7:0] CCP_IDX_CTL = 8'h17;
    localparam logic [7:0] CCP_IDX_PIN_DIR = 8'h87;
    localparam logic [7:0] CCP_IDX_PENABLES = 8'h8C;
    localparam logic [7:0] CCP_IDX_T2_PER = 8'h92;

    ////////////////////////////////////////////////////////////////////////////////
    // Field positions and masks
    localparam int CCP_FLAG_T1_OVF = 0;
    localparam int CCP_FLAG_T2 = 1;
    localparam int CCP_FLAG_UNIT = 2;
    localparam int CCP_TRIS_BIT = 2;
    localparam int CCP_DATA_BIT = 2;
    localparam int CCP_T1_ON_BIT = 0;
    localparam int CCP_T2_ON_BIT = 2;
    localparam logic [7:0] CCP_FLAG_MASK = 8'h07;
    localparam logic [7:0] CCP_CTL_MASK = 8'h3F;
    localparam logic [7:0] CCP_T1_CTL_MASK = 8'h3F;
    localparam logic [7:0] CCP_T2_CTL_MASK = 8'h7F;

    ////////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [7:0] CCP_RST_ZERO = 8'h00;
    localparam logic [7:0] CCP_RST_PIN_DIR = 8'hFF;
    localparam logic [7:0] CCP_RST_T2_PER = 8'hFF;

    ////////////////////////////////////////////////////////////////////////////////
    // Counts: clock phases per instruction cycle, prescaler tops
    localparam logic [1:0] CCP_Q_LAST = 2'h3;
    localparam logic [3:0] CCP_T2_TOP_1 = 4'h0;
    localparam logic [3:0] CCP_T2_TOP_4 = 4'h3;
    localparam logic [3:0] CCP_T2_TOP_16 = 4'hF;
    localparam logic [3:0] CCP_CAP_TOP_4 = 4'h3;
    localparam logic [3:0] CCP_CAP_TOP_16 = 4'hF;

    ////////////////////////////////////////////////////////////////////////////////
    // Unit modes
    typedef enum logic [3:0] {
        CCP_MODE_OFF = 4'b0000,
        CCP_MODE_CAP_FALL = 4'b0100,
        CCP_MODE_CAP_RISE = 4'b0101,
        CCP_MODE_CAP_RISE4 = 4'b0110,
        CCP_MODE_CAP_RISE16 = 4'b0111,
        CCP_MODE_CMP_SET = 4'b1000,
        CCP_MODE_CMP_CLR = 4'b1001,
        CCP_MODE_CMP_SWI = 4'b1010,
        CCP_MODE_CMP_SPEC = 4'b1011,
        CCP_MODE_PWM0 = 4'b1100,
        CCP_MODE_PWM1 = 4'b1101,
        CCP_MODE_PWM2 = 4'b1110,
        CCP_MODE_PWM3 = 4'b1111
    } ccp_mode_t;

    ////////////////////////////////////////////////////////////////////////////////
    // Timer2 carriers and state
    typedef struct packed {
        logic on;
        logic [1:0] ckps;
        logic [3:0] outps;
        logic [7:0] period;
    } ccp_t2_cfg_t;

    typedef struct packed {
        logic [7:0] count;
        logic [1:0] tb_low;
        logic period_hit;
        logic post_flag;
    } ccp_t2_stat_t;

    typedef struct packed {
        logic [7:0] count;
        logic [3:0] pre;
        logic [3:0] post;
        logic period_hit;
        logic post_flag;
    } ccp_t2_state_t;

    ////////////////////////////////////////////////////////////////////////////////
    // Main unit state
    typedef struct packed {
        logic [7:0] flags;
        logic [7:0] enables;
        logic [7:0] t1_lo;
        logic [7:0] t1_hi;
        logic [7:0] t1_ctl;
        logic [7:0] val_lo;
        logic [7:0] val_hi;
        logic [7:0] ctl;
        logic [7:0] pin_dir;
        logic [7:0] pin_data;
        logic [7:0] t2_ctl;
        logic [7:0] t2_per;
        logic [1:0] q;
        logic [2:0] t1_pre;
        logic t1_inc;
        logic [3:0] cap_pre;
        logic pin_prev;
        logic unit_out;
        logic [1:0] dc_latch;
        logic ack;
        logic [7:0] rdata;
        logic adc_start;
    } ccp_state_t;

endpackage

/* File: hw/ccp_timer2_count.sv */
// Timer2 time base with 1/4/16 prescaler, period match and postscaler
`timescale 1ns/10ps
`default_nettype none

module ccp_timer2_count (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Instruction-cycle strobe and phase
    input wire logic tick,
    input wire logic [1:0] q,
    // Configuration and software count write
    input wire ccp_pkg::ccp_t2_cfg_t cfg,
    input wire logic wr_count,
    input wire logic [7:0] wr_data,
    // Status
    output ccp_pkg::ccp_t2_stat_t stat
);
    import ccp_pkg::*;

    ccp_t2_state_t s_q;
    ccp_t2_state_t s_d;
    logic [3:0] top;

    always_comb begin
        s_d = s_q;
        s_d.period_hit = 1'b0;
        s_d.post_flag = 1'b0;
        unique case (cfg.ckps)
            2'b00: top = CCP_T2_TOP_1;
            2'b01: top = CCP_T2_TOP_4;
            default: top = CCP_T2_TOP_16;
        endcase
        if (wr_count) begin
            s_d.count = wr_data;
            s_d.pre = 4'h0;
        end else if (cfg.on && tick) begin
            if (s_q.pre >= top) begin
                s_d.pre = 4'h0;
                if (s_q.count == cfg.period) begin
                    s_d.count = 8'h00;
                    s_d.period_hit = 1'b1;
                    if (s_q.post == cfg.outps) begin
                        s_d.post = 4'h0;
                        s_d.post_flag = 1'b1;
                    end else begin
                        s_d.post = s_q.post + 4'h1;
                    end
                end else begin
                    s_d.count = s_q.count + 8'h01;
                end
            end else begin
                s_d.pre = s_q.pre + 4'h1;
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    always_comb begin
        stat.count = s_q.count;
        stat.period_hit = s_q.period_hit;
        stat.post_flag = s_q.post_flag;
        // low two bits of 10-bit time base
        unique case (cfg.ckps)
            2'b00: stat.tb_low = q;
            2'b01: stat.tb_low = s_q.pre[1:0];
            default: stat.tb_low = s_q.pre[3:2];
        endcase
    end

endmodule // ccp_timer2_count

`default_nettype wire

/* File: hw/ccp_unit.sv */
// Capture/compare/PWM unit with Timer1, Timer2 and an Avalon-MM register slave
`timescale 1ns/10ps
`default_nettype none

module ccp_unit (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Avalon-MM slave
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Unit pin
    input wire logic unit_pin_in,
    output logic unit_pin_out,
    output logic unit_pin_oe_n,
    // Converter trigger and peripheral request
    input wire logic adc_enabled,
    output logic adc_start,
    output logic periph_irq
);
    import ccp_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // State and helpers
    ccp_state_t s_q;
    ccp_state_t s_d;
    ccp_t2_cfg_t t2_cfg;
    ccp_t2_stat_t t2_stat;
    ccp_mode_t mode;
    logic [7:0] idx;
    logic req;
    logic wr_en;
    logic [7:0] wd;
    logic tick;
    logic is_cap;
    logic is_cmp;
    logic is_pwm;
    logic drive_unit;
    logic pin_level;
    logic rise;
    logic fall;
    logic cap_ev;
    logic match_ev;
    logic t1_wr;
    logic [15:0] t1;
    logic [2:0] t1_top;
    logic t2_wr;

    function automatic logic [7:0] reg_read(input ccp_state_t s, input logic [7:0] i,
                                            input logic pin, input logic [7:0] t2c);
        logic [7:0] r;
        r = 8'h00;
        unique case (i)
            CCP_IDX_PIN_DATA: begin
                r = s.pin_data;
                r[CCP_DATA_BIT] = pin;
            end
            CCP_IDX_PFLAGS: r = s.flags;
            CCP_IDX_T1_LO: r = s.t1_lo;
            CCP_IDX_T1_HI: r = s.t1_hi;
            CCP_IDX_T1_CTL: r = s.t1_ctl;
            CCP_IDX_T2_CNT: r = t2c;
            CCP_IDX_T2_CTL: r = s.t2_ctl;
            CCP_IDX_VAL_LO: r = s.val_lo;
            CCP_IDX_VAL_HI: r = s.val_hi;
            CCP_IDX_CTL: r = s.ctl;
            CCP_IDX_PIN_DIR: r = s.pin_dir;
            CCP_IDX_PENABLES: r = s.enables;
            CCP_IDX_T2_PER: r = s.t2_per;
            default: r = 8'h00;
        endcase
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Decode
    always_comb begin
        idx = avs_address[9:2];
        req = avs_read | avs_write;
        wr_en = s_q.ack & avs_write & avs_byteenable[0];
        wd = avs_writedata[7:0];
        tick = (s_q.q == CCP_Q_LAST);
        mode = ccp_mode_t'(s_q.ctl[3:0]);
        is_cap = (s_q.ctl[3:2] == 2'b01);
        is_cmp = (s_q.ctl[3:2] == 2'b10);
        is_pwm = (s_q.ctl[3:2] == 2'b11);
        drive_unit = is_cmp | is_pwm;
        unit_pin_out = drive_unit ? s_q.unit_out : s_q.pin_data[CCP_DATA_BIT];
        unit_pin_oe_n = s_q.pin_dir[CCP_TRIS_BIT];
        pin_level = unit_pin_oe_n ? unit_pin_in : unit_pin_out;
        rise = pin_level & ~s_q.pin_prev;
        fall = ~pin_level & s_q.pin_prev;
        t1 = {s_q.t1_hi, s_q.t1_lo};
        t1_top = 3'((4'h1 << s_q.t1_ctl[5:4]) - 4'h1);
        t1_wr = wr_en & ((idx == CCP_IDX_T1_LO) | (idx == CCP_IDX_T1_HI));
        t2_wr = wr_en & (idx == CCP_IDX_T2_CNT);
        // compare valid only in the cycle after a Timer1 increment
        match_ev = is_cmp & s_q.t1_inc & (t1 == {s_q.val_hi, s_q.val_lo});
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Timer2
    always_comb begin
        t2_cfg.on = s_q.t2_ctl[CCP_T2_ON_BIT];
        t2_cfg.ckps = s_q.t2_ctl[1:0];
        t2_cfg.outps = s_q.t2_ctl[6:3];
        t2_cfg.period = s_q.t2_per;
    end

    ccp_timer2_count u_timer2_count (
        .mclk(mclk),
        .rst(rst),
        .tick(tick),
        .q(s_q.q),
        .cfg(t2_cfg),
        .wr_count(t2_wr),
        .wr_data(wd),
        .stat(t2_stat)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        s_d = s_q;
        s_d.ack = req & ~s_q.ack;
        s_d.adc_start = 1'b0;
        s_d.t1_inc = 1'b0;
        s_d.q = s_q.q + 2'h1;
        s_d.pin_prev = pin_level;
        cap_ev = 1'b0;
        if (req & ~s_q.ack) begin
            s_d.rdata = reg_read(s_q, idx, pin_level, t2_stat.count);
        end

        // Software writes
        if (wr_en) begin
            unique case (idx)
                CCP_IDX_PIN_DATA: s_d.pin_data = wd;
                CCP_IDX_PFLAGS: s_d.flags = wd & CCP_FLAG_MASK;
                CCP_IDX_T1_LO: s_d.t1_lo = wd;
                CCP_IDX_T1_HI: s_d.t1_hi = wd;
                CCP_IDX_T1_CTL: s_d.t1_ctl = wd & CCP_T1_CTL_MASK;
                CCP_IDX_T2_CTL: s_d.t2_ctl = wd & CCP_T2_CTL_MASK;
                CCP_IDX_VAL_LO: s_d.val_lo = wd;
                CCP_IDX_VAL_HI: begin
                    if (!is_pwm) begin
                        s_d.val_hi = wd;
                    end
                end
                CCP_IDX_CTL: s_d.ctl = wd & CCP_CTL_MASK;
                CCP_IDX_PIN_DIR: s_d.pin_dir = wd;
                CCP_IDX_PENABLES: s_d.enables = wd & CCP_FLAG_MASK;
                CCP_IDX_T2_PER: s_d.t2_per = wd;
                default: s_d.enables = s_d.enables;
            endcase
        end

        // Timer1 increment every 1, 2, 4 or 8 instruction cycles, set by the prescaler
        if (!t1_wr && s_q.t1_ctl[CCP_T1_ON_BIT] && tick) begin
            if (s_q.t1_pre >= t1_top) begin
                s_d.t1_pre = 3'h0;
                s_d.t1_inc = 1'b1;
                {s_d.t1_hi, s_d.t1_lo} = t1 + 16'h0001;
                if (t1 == 16'hFFFF) begin
                    s_d.flags[CCP_FLAG_T1_OVF] = 1'b1;
                end
            end else begin
                s_d.t1_pre = s_q.t1_pre + 3'h1;
            end
        end

        // Capture
        if (!is_cap) begin
            s_d.cap_pre = 4'h0;
        end else begin
            // prescale count kept across capture modes
            unique case (mode)
                CCP_MODE_CAP_FALL: cap_ev = fall;
                CCP_MODE_CAP_RISE: cap_ev = rise;
                CCP_MODE_CAP_RISE4, CCP_MODE_CAP_RISE16: begin
                    if (rise) begin
                        if (s_q.cap_pre >= ((mode == CCP_MODE_CAP_RISE4) ? CCP_CAP_TOP_4
                                                                        : CCP_CAP_TOP_16)) begin
                            s_d.cap_pre = 4'h0;
                            cap_ev = 1'b1;
                        end else begin
                            s_d.cap_pre = s_q.cap_pre + 4'h1;
                        end
                    end
                end
                default: cap_ev = 1'b0;
            endcase
        end
        if (cap_ev) begin
            s_d.val_lo = s_q.t1_lo;
            s_d.val_hi = s_q.t1_hi;
            s_d.flags[CCP_FLAG_UNIT] = 1'b1;
        end

        // Compare
        if (match_ev) begin
            s_d.flags[CCP_FLAG_UNIT] = 1'b1;
            unique case (mode)
                CCP_MODE_CMP_SET: s_d.unit_out = 1'b1;
                CCP_MODE_CMP_CLR: s_d.unit_out = 1'b0;
                CCP_MODE_CMP_SPEC: begin
                    s_d.t1_lo = 8'h00;
                    s_d.t1_hi = 8'h00;
                    s_d.t1_pre = 3'h0;
                    s_d.adc_start = adc_enabled;
                end
                default: s_d.unit_out = s_q.unit_out;
            endcase
        end

        // PWM
        if (is_pwm) begin
            // period from Timer2 period and prescale
            if (t2_stat.period_hit) begin
                // load duty, set pin unless zero
                // duty from value byte and control bits
                s_d.val_hi = s_q.val_lo;
                s_d.dc_latch = s_q.ctl[5:4];
                s_d.unit_out = ({s_q.val_lo, s_q.ctl[5:4]} != 10'h000);
            end else if ({s_q.val_hi, s_q.dc_latch} == {t2_stat.count, t2_stat.tb_low}) begin
                // no match when duty exceeds period
                s_d.unit_out = 1'b0;
            end
        end

        if (t2_stat.post_flag) begin
            s_d.flags[CCP_FLAG_T2] = 1'b1;
        end

        if (s_d.ctl[3:0] == 4'h0) begin
            s_d.unit_out = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
            s_q.flags <= CCP_RST_ZERO;
            s_q.enables <= CCP_RST_ZERO;
            s_q.ctl <= CCP_RST_ZERO;
            s_q.pin_dir <= CCP_RST_PIN_DIR;
            s_q.t2_per <= CCP_RST_T2_PER;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs
    always_comb begin
        avs_waitrequest = req & ~s_q.ack;
        avs_readdata = {24'h000000, s_q.rdata};
        adc_start = s_q.adc_start;
        // flag reaches the request only when enabled
        periph_irq = |(s_q.flags & s_q.enables);
    end

endmodule // ccp_unit

`default_nettype wire

/* File: sim/ccp_unit_props.sv */
// Concurrent checks on the ports of the capture/compare/PWM unit
`timescale 1ns/10ps
`default_nettype none

module ccp_unit_props
    import ccp_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Register bus
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // Pin, converter enable input and side outputs
    input wire logic unit_pin_oe_n,
    input wire logic adc_enabled,
    input wire logic adc_start,
    input wire logic periph_irq
);
    logic req, wr_ok, dir_wr, en_seen_q;
    assign req = avs_read | avs_write;
    assign wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
    assign dir_wr = wr_ok && avs_address[9:2] == CCP_IDX_PIN_DIR;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            en_seen_q <= 1'b0;
        end else if (wr_ok && avs_address[9:2] == CCP_IDX_PENABLES
                     && avs_writedata[7:0] != 8'h00) begin
            en_seen_q <= 1'b1;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////////////
    property p_wait_first;
        req && !$past(req) |-> avs_waitrequest ##1 !avs_waitrequest;
    endproperty
    a_wait_first: assert property (p_wait_first) else $error("waitrequest timing wrong");
    property p_idle;
        !req |-> !avs_waitrequest;
    endproperty
    a_idle: assert property (p_idle) else $error("waitrequest high while idle");
    property p_rdata;
        avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h000000;
    endproperty
    a_rdata: assert property (p_rdata) else $error("read data upper bits set");
    property p_oe_cause;
        $changed(unit_pin_oe_n) |-> $past(dir_wr);
    endproperty
    a_oe_cause: assert property (p_oe_cause) else $error("pin enable moved by itself");
    property p_oe_value;
        dir_wr |=> unit_pin_oe_n == $past(avs_writedata[2]);
    endproperty
    a_oe_value: assert property (p_oe_value) else $error("pin enable not bit 2");
    property p_adc_pulse;
        adc_start |=> !adc_start;
    endproperty
    a_adc_pulse: assert property (p_adc_pulse) else $error("start pulse too long");
    property p_adc_gate;
        adc_start |-> adc_enabled || $past(adc_enabled) || $past(adc_enabled, 2);
    endproperty
    a_adc_gate: assert property (p_adc_gate) else $error("start while converter off");
    property p_irq_quiet;
        !en_seen_q |-> !periph_irq;
    endproperty
    a_irq_quiet: assert property (p_irq_quiet) else $error("request while disabled");
    c_adc: cover property (adc_start);
    c_drive: cover property ($fell(unit_pin_oe_n));
    c_irq: cover property (periph_irq);
endmodule // ccp_unit_props

bind ccp_unit ccp_unit_props u_props (.mclk, .rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .unit_pin_oe_n,
    .adc_enabled, .adc_start, .periph_irq);
`default_nettype wire

/* File: sim/ccp_pin_model.sv */
// External circuit on the unit pin, with a pull-up when nobody drives
`timescale 1ns/10ps
`default_nettype none

module ccp_pin_model (
    // Unit side
    input wire logic pin_out,
    input wire logic oe_n,
    // Outside driver
    input wire logic ext_en,
    input wire logic ext_lvl,
    // Wire level seen by the unit
    output logic pin
);
    assign pin = !oe_n ? pin_out : (ext_en ? ext_lvl : 1'b1);
endmodule // ccp_pin_model
`default_nettype wire

/* File: sim/ccp_unit_tb_top.sv */
// Self-checking testbench of the capture/compare/PWM unit
`timescale 1ns/10ps
`default_nettype none

module ccp_unit_tb_top;
    import ccp_pkg::*;
    typedef struct packed {logic w; logic [7:0] i; logic [7:0] d; logic [7:0] e;} ccp_row_t;
    logic mclk, rst, avs_read, avs_write, adc_enabled, ext_en, ext_lvl;
    logic avs_waitrequest, unit_pin_in, unit_pin_out, unit_pin_oe_n, adc_start, periph_irq;
    logic [9:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0] avs_byteenable;
    logic [7:0] rd, v1;
    int errors, n_checks, k, n;
    ccp_row_t rows [12] = '{'{1'b0, CCP_IDX_CTL, 8'h00, 8'h00},
        '{1'b0, CCP_IDX_PFLAGS, 8'h00, 8'h00},
        '{1'b0, CCP_IDX_PIN_DIR, 8'h00, 8'hFF}, '{1'b0, CCP_IDX_T2_PER, 8'h00, 8'hFF},
        '{1'b0, CCP_IDX_PENABLES, 8'h00, 8'h00}, '{1'b0, 8'h0B, 8'h00, 8'h00},
        '{1'b1, CCP_IDX_CTL, 8'hFF, 8'h3F}, '{1'b1, CCP_IDX_CTL, 8'h00, 8'h00},
        '{1'b1, CCP_IDX_VAL_LO, 8'hA5, 8'hA5}, '{1'b1, CCP_IDX_VAL_HI, 8'h5A, 8'h5A},
        '{1'b1, CCP_IDX_T2_PER, 8'h03, 8'h03}, '{1'b1, 8'h20, 8'hFF, 8'h00}};

    ccp_unit uut (.mclk(mclk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .unit_pin_in(unit_pin_in), .unit_pin_out(unit_pin_out), .unit_pin_oe_n(unit_pin_oe_n),
        .adc_enabled(adc_enabled), .adc_start(adc_start), .periph_irq(periph_irq));
    ccp_pin_model u_pin (.pin_out(unit_pin_out), .oe_n(unit_pin_oe_n), .ext_en(ext_en),
        .ext_lvl(ext_lvl), .pin(unit_pin_in));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] i, input logic [7:0] d);
        int c;
        c = 0;
        @(posedge mclk);
        avs_address <= {i, 2'b00};
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= {24'h000000, d};
        do begin
            @(posedge mclk);
            c++;
        end while (avs_waitrequest !== 1'b0 && c < 100);
        if (c >= 100) errors++;
        rd = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        bus(1'b1, i, d);
    endtask
    task automatic rdc(input string nm, input logic [7:0] i, input logic [7:0] e);
        bus(1'b0, i, 8'h00);
        chk(nm, {8'h00, rd}, {8'h00, e});
    endtask
    task automatic wait_pin(input logic v);
        n = 0;
        while (unit_pin_out !== v && n < 600) begin
            @(negedge mclk);
            n++;
        end
        chk("pin_level", {15'h0000, unit_pin_out}, {15'h0000, v});
    endtask
    task automatic pwm(input int hi, input int per);
        int h;
        wait_pin(1'b0);
        wait_pin(1'b1);
        wait_pin(1'b0);
        wait_pin(1'b1);
        h = 0;
        while (unit_pin_out === 1'b1 && h < 600) begin
            @(negedge mclk);
            h++;
        end
        chk("pwm_high", h[15:0], hi[15:0]);
        while (unit_pin_out === 1'b0 && h < 600) begin
            @(negedge mclk);
            h++;
        end
        chk("pwm_period", h[15:0], per[15:0]);
    endtask
    task automatic hold(input logic v);
        h_loop: for (int c = 0; c < 60; c++) begin
            @(negedge mclk);
            if (unit_pin_out !== v) n++;
        end
    endtask
    task automatic wrap_up;
        if (errors == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    initial begin
        repeat (40000) @(posedge mclk);
        errors++;
        wrap_up();
    end
    initial begin
        {rst, avs_read, avs_write, adc_enabled, ext_en, ext_lvl} = 6'b100000;
        {avs_address, avs_writedata, avs_byteenable, errors, n_checks} = '0;
        avs_byteenable = 4'h1;
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        chk("oe_n_reset", {15'h0000, unit_pin_oe_n}, 16'h0001);
        chk("pin_reset", {15'h0000, unit_pin_out}, 16'h0000);
        foreach (rows[k]) begin
            if (rows[k].w) wr(rows[k].i, rows[k].d);
            rdc("reg", rows[k].i, rows[k].e);
        end
        avs_byteenable <= 4'h0;
        wr(CCP_IDX_VAL_LO, 8'h11);
        avs_byteenable <= 4'h1;
        rdc("byte_off", CCP_IDX_VAL_LO, 8'hA5);
        wr(CCP_IDX_PIN_DIR, 8'hFB);
        wr(CCP_IDX_VAL_HI, 8'h00);
        wr(CCP_IDX_VAL_LO, 8'h20);
        wr(CCP_IDX_T1_CTL, 8'h01);
        wr(CCP_IDX_CTL, 8'h08);
        wait_pin(1'b1);
        rdc("cmp_flag", CCP_IDX_PFLAGS, 8'h04);
        wr(CCP_IDX_CTL, 8'h09);
        wr(CCP_IDX_T1_LO, 8'h00);
        wait_pin(1'b0);
        wr(CCP_IDX_PFLAGS, 8'h00);
        wr(CCP_IDX_PENABLES, 8'h04);
        wr(CCP_IDX_CTL, 8'h0A);
        wr(CCP_IDX_T1_LO, 8'h00);
        repeat (300) @(posedge mclk);
        rdc("swi_flag", CCP_IDX_PFLAGS, 8'h04);
        chk("swi_pin", {15'h0000, unit_pin_out}, 16'h0000);
        chk("irq_on", {15'h0000, periph_irq}, 16'h0001);
        wr(CCP_IDX_PFLAGS, 8'h00);
        @(posedge mclk);
        chk("irq_off", {15'h0000, periph_irq}, 16'h0000);
        adc_enabled <= 1'b1;
        wr(CCP_IDX_CTL, 8'h0B);
        wr(CCP_IDX_T1_LO, 8'h00);
        n = 0;
        while (adc_start !== 1'b1 && n < 600) begin
            @(negedge mclk);
            n++;
        end
        chk("adc_start", {15'h0000, adc_start}, 16'h0001);
        bus(1'b0, CCP_IDX_T1_LO, 8'h00);
        chk("t1_reset", {15'h0000, rd < 8'h20}, 16'h0001);
        rdc("sev_flags", CCP_IDX_PFLAGS, 8'h04);
        wr(CCP_IDX_CTL, 8'h00);
        @(posedge mclk);
        chk("latch_low", {15'h0000, unit_pin_out}, 16'h0000);
        wr(CCP_IDX_T2_PER, 8'h03);
        wr(CCP_IDX_VAL_LO, 8'h02);
        for (k = 0; k < 3; k++) begin
            wr(CCP_IDX_T2_CTL, 8'h04 | k[7:0]);
            wr(CCP_IDX_CTL, 8'h0C);
            pwm(8 << (2 * k), 16 << (2 * k));
        end
        wr(CCP_IDX_T2_CTL, 8'h04);
        wr(CCP_IDX_CTL, 8'h2C);
        pwm(10, 16);
        wr(CCP_IDX_VAL_HI, 8'h77);
        rdc("hi_locked", CCP_IDX_VAL_HI, 8'h02);
        wr(CCP_IDX_VAL_LO, 8'hFF);
        wait_pin(1'b0);
        wait_pin(1'b1);
        n = 0;
        hold(1'b1);
        chk("long_duty", n[15:0], 16'h0000);
        wr(CCP_IDX_CTL, 8'h00);
        wr(CCP_IDX_CTL, 8'h0A);
        @(posedge mclk);
        chk("latch_off", {15'h0000, unit_pin_out}, 16'h0000);
        wr(CCP_IDX_VAL_LO, 8'h00);
        wr(CCP_IDX_CTL, 8'h0C);
        repeat (40) @(posedge mclk);
        n = 0;
        hold(1'b0);
        chk("zero_duty", n[15:0], 16'h0000);
        wr(CCP_IDX_T2_CTL, 8'h00);
        wr(CCP_IDX_CTL, 8'h00);
        wr(CCP_IDX_PIN_DIR, 8'hFF);
        ext_en <= 1'b1;
        wr(CCP_IDX_CTL, 8'h05);
        wr(CCP_IDX_PFLAGS, 8'h00);
        ext_lvl <= 1'b1;
        repeat (8) @(posedge mclk);
        rdc("cap_flag", CCP_IDX_PFLAGS, 8'h04);
        bus(1'b0, CCP_IDX_VAL_LO, 8'h00);
        v1 = rd;
        ext_lvl <= 1'b0;
        repeat (40) @(posedge mclk);
        ext_lvl <= 1'b1;
        repeat (8) @(posedge mclk);
        bus(1'b0, CCP_IDX_VAL_LO, 8'h00);
        chk("cap_new", {15'h0000, rd !== v1}, 16'h0001);
        wr(CCP_IDX_CTL, 8'h06);
        wr(CCP_IDX_PFLAGS, 8'h00);
        for (k = 0; k < 4; k++) begin
            ext_lvl <= 1'b0;
            repeat (4) @(posedge mclk);
            ext_lvl <= 1'b1;
            repeat (4) @(posedge mclk);
            rdc("cap4_flag", CCP_IDX_PFLAGS, (k == 3) ? 8'h04 : 8'h00);
        end
        wrap_up();
    end
endmodule // ccp_unit_tb_top
`default_nettype wire
